// ### core/tss_status_words.sv
// module: trace control and system status words behind a simple register port
//
// Behaviour
// - done flag sets at trace end, clears on start
// - busy sets on sampling start, clears when done
// - trigger bit rise fixes trigger; signed delay window
// - sampling start rise begins storing by mode
// - periodic mode samples every programmed 10-2550 ms
// - instruction mode samples per trace sample instruction
// - cycle mode samples at every cycle end
// - refresh bit updates stored slave error unit
// - power-on captures current time into start-up words
// - seconds,minutes in the low half, hours,day in the high half of one word
// - power loss captures time; kept over start-up
// - loss counter kept, cleared on corruption, writable zero
// - on-time counts 10-hour units, writable zero
// - serial restart bit self-clears after restart completes
// - peripheral restart bit rise restarts peripheral port
// - master restart bits restart units, self-clear
`timescale 1ns/100ps
module tss_status_words #(
	parameter int     DEPTH      = 64,
	parameter longint ON_UNIT    = tss_pkg::ON_UNIT_CYC,
	parameter int     IVAL_UNIT  = tss_pkg::UNIT_CYC
) (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	// register port
	input  wire tss_pkg::tss_bus_t bus_i,
	output logic [31:0]            rdata_o,
	// cpu events
	input  wire logic              power_on_i,
	input  wire logic              power_loss_i,
	input  wire logic              mem_corrupt_i,
	input  wire logic              cycle_end_i,
	input  wire logic              trace_sample_instruction_i,
	input  wire tss_pkg::tss_time_t now_i,
	input  wire logic [15:0]       slv_err_unit_i,
	// trace sampling
	output logic                   sample_o,
	output logic [15:0]            sample_idx_o,
	output logic                   trig_o,
	// port restarts
	output logic                   ser_restart_o,
	output logic                   per_restart_o,
	output logic                   m1_restart_o,
	output logic                   m0_restart_o,
	input  wire logic              ser_done_i,
	input  wire logic              m1_done_i,
	input  wire logic              m0_done_i
);
	tss_pkg::tss_state_t st_ff, nxt_st;
	logic [15:0] ctrl_ff;
	logic [31:0] cfg_ff;
	logic [15:0] slv_ff;
	logic [31:0] start_ts_ff;
	logic [31:0] loss_ts_ff;
	logic [15:0] loss_cnt_ff;
	logic [15:0] on_hrs_ff;
	logic [63:0] on_tick_ff;
	logic [31:0] ival_ff;
	logic [15:0] cnt_ff;
	logic [15:0] post_ff;
	logic [31:0] rdata_ff;
	logic        done_ff;
	logic        tmon_ff;

	logic wr_ctrl, wr_cfg, wr_slv, wr_cnt, wr_hrs, wr_rst;
	logic smp_rise, trg_rise, smp_tick, ival_hit, full, post_end;
	logic [15:0] wd16;
	logic [15:0] delay;
	logic [7:0]  ival_n;
	tss_pkg::tss_mode_t mode;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] idx);
		return bus_i.wr && (a == idx);
	endfunction

	// a value is valid bcd only when both nibbles stay below ten
	function automatic logic [7:0] bcd_ok(input logic [7:0] v);
		return (v[7:4] < 4'ha && v[3:0] < 4'ha) ? v : 8'h00;
	endfunction

	function automatic logic [31:0] pack_ts(input tss_pkg::tss_time_t t);
		return {bcd_ok(t.day), bcd_ok(t.hour), bcd_ok(t.minute), bcd_ok(t.second)};
	endfunction

	assign wd16    = bus_i.wdata[15:0];
	assign wr_ctrl = hit(bus_i.addr, tss_pkg::TRACE_CTRL_IDX);
	assign wr_cfg  = hit(bus_i.addr, tss_pkg::TRACE_CFG_IDX);
	assign wr_slv  = hit(bus_i.addr, tss_pkg::SLV_REFRESH_IDX);
	assign wr_cnt  = hit(bus_i.addr, tss_pkg::LOSS_CNT_IDX);
	assign wr_hrs  = hit(bus_i.addr, tss_pkg::ON_HOURS_IDX);
	assign wr_rst  = hit(bus_i.addr, tss_pkg::RESTART_IDX);

	assign mode   = tss_pkg::tss_mode_t'(cfg_ff[tss_pkg::CFG_MODE_LSB +: 2]);
	assign ival_n = cfg_ff[tss_pkg::CFG_IVAL_LSB +: 8];
	assign delay  = cfg_ff[tss_pkg::CFG_DELAY_LSB +: 16];

	assign smp_rise = wr_ctrl & wd16[tss_pkg::TRC_SAMPLE_BIT]
		& ~ctrl_ff[tss_pkg::TRC_SAMPLE_BIT];
	assign trg_rise = wr_ctrl & wd16[tss_pkg::TRC_TRIG_BIT]
		& ~ctrl_ff[tss_pkg::TRC_TRIG_BIT] & (st_ff == tss_pkg::TRC_RUN);

	// interval count of 10 ms units, zero treated as the shortest interval
	assign ival_hit = (ival_ff >= (32'(ival_n == 8'h00 ? 8'h01 : ival_n) * 32'(IVAL_UNIT)) - 32'd1);
	assign smp_tick = (st_ff != tss_pkg::TRC_IDLE) && (
		(mode == tss_pkg::SMP_PERIODIC && ival_hit) ||
		(mode == tss_pkg::SMP_INSTR && trace_sample_instruction_i) ||
		(mode == tss_pkg::SMP_CYCLE && cycle_end_i));
	assign full     = (cnt_ff == 16'(DEPTH - 1)) && smp_tick;
	assign post_end = (st_ff == tss_pkg::TRC_POST) && smp_tick && (post_ff == 16'h0000);

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			tss_pkg::TRC_IDLE: begin
				if (smp_rise) nxt_st = tss_pkg::TRC_RUN;
			end
			tss_pkg::TRC_RUN: begin
				if (trg_rise) nxt_st = tss_pkg::TRC_POST;
				else if (full && !tmon_ff) nxt_st = tss_pkg::TRC_RUN;
			end
			tss_pkg::TRC_POST: begin
				if (post_end || full) nxt_st = tss_pkg::TRC_IDLE;
			end
			default: nxt_st = tss_pkg::TRC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff   <= tss_pkg::TRC_IDLE;
			ctrl_ff <= tss_pkg::TRACE_CTRL_RST;
			cfg_ff  <= tss_pkg::TRACE_CFG_RST;
			done_ff <= 1'b0;
			tmon_ff <= 1'b0;
			ival_ff <= 32'h0000_0000;
			cnt_ff  <= 16'h0000;
			post_ff <= 16'h0000;
		end else begin
			st_ff <= nxt_st;
			if (wr_ctrl) begin
				ctrl_ff[tss_pkg::TRC_SAMPLE_BIT] <= wd16[tss_pkg::TRC_SAMPLE_BIT];
				ctrl_ff[tss_pkg::TRC_TRIG_BIT]   <= wd16[tss_pkg::TRC_TRIG_BIT];
			end
			if (wr_cfg) cfg_ff <= bus_i.wdata;
			if (st_ff == tss_pkg::TRC_POST && nxt_st == tss_pkg::TRC_IDLE) begin
				done_ff <= 1'b1;
			end else if (smp_rise) begin
				done_ff <= 1'b0;
			end
			if (trg_rise) begin
				tmon_ff <= 1'b1;
				// positive delay keeps samples after trigger, negative ends at the first sample after it
				post_ff <= delay[15] ? 16'h0000 : delay;
			end else if (smp_rise) begin
				tmon_ff <= 1'b0;
			end else if (st_ff == tss_pkg::TRC_POST && smp_tick && post_ff != 16'h0000) begin
				post_ff <= post_ff - 16'h0001;
			end
			if (smp_rise) begin
				cnt_ff  <= 16'h0000;
				ival_ff <= 32'h0000_0000;
			end else if (smp_tick) begin
				cnt_ff  <= (cnt_ff == 16'(DEPTH - 1)) ? 16'h0000 : cnt_ff + 16'h0001;
				ival_ff <= 32'h0000_0000;
			end else if (st_ff != tss_pkg::TRC_IDLE) begin
				ival_ff <= ival_ff + 32'h0000_0001;
			end
		end
	end

	assign sample_o     = smp_tick;
	assign sample_idx_o = cnt_ff;
	assign trig_o       = trg_rise;

	// power-related words have no reset: they are meant to survive start-up
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			start_ts_ff <= pack_ts(now_i);
		end
		if (power_loss_i) begin
			loss_ts_ff <= pack_ts(now_i);
		end
		if (mem_corrupt_i) begin
			loss_cnt_ff <= 16'h0000;
		end else if (power_loss_i) begin
			loss_cnt_ff <= loss_cnt_ff + 16'h0001;
		end else if (wr_cnt) begin
			loss_cnt_ff <= wd16;
		end
		if (on_tick_ff >= ON_UNIT - 64'd1) begin
			on_tick_ff <= 64'd0;
			on_hrs_ff  <= on_hrs_ff + 16'h0001;
		end else begin
			on_tick_ff <= on_tick_ff + 64'd1;
			if (wr_hrs) on_hrs_ff <= wd16;
		end
		if (power_on_i) on_tick_ff <= 64'd0;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slv_ff <= 16'h0000;
		end else if (wr_slv && bus_i.wdata[tss_pkg::SLV_REFR_BIT]) begin
			slv_ff <= slv_err_unit_i;
		end
	end

	logic ser_b, per_b, m1_b, m0_b;

	tss_restart #(.AUTO_CLEAR(1'b1)) u_ser (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.set_i     (wr_rst & wd16[tss_pkg::RST_SER_BIT]),
		.clr_i     (1'b0),
		.done_i    (ser_done_i),
		.bit_o     (ser_b),
		.pulse_o   (ser_restart_o)
	);
	// the peripheral bit has no completion report, so software clears it
	tss_restart #(.AUTO_CLEAR(1'b0)) u_per (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.set_i     (wr_rst & wd16[tss_pkg::RST_PER_BIT]),
		.clr_i     (wr_rst & ~wd16[tss_pkg::RST_PER_BIT]),
		.done_i    (1'b0),
		.bit_o     (per_b),
		.pulse_o   (per_restart_o)
	);
	tss_restart #(.AUTO_CLEAR(1'b1)) u_m1 (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.set_i     (wr_rst & wd16[tss_pkg::RST_M1_BIT]),
		.clr_i     (1'b0),
		.done_i    (m1_done_i),
		.bit_o     (m1_b),
		.pulse_o   (m1_restart_o)
	);
	tss_restart #(.AUTO_CLEAR(1'b1)) u_m0 (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.set_i     (wr_rst & wd16[tss_pkg::RST_M0_BIT]),
		.clr_i     (1'b0),
		.done_i    (m0_done_i),
		.bit_o     (m0_b),
		.pulse_o   (m0_restart_o)
	);

	logic [15:0] ctrl_rd, rst_rd;
	logic [31:0] rmux;
	assign ctrl_rd = {ctrl_ff[15:14], st_ff != tss_pkg::TRC_IDLE, done_ff,
		tmon_ff, 11'h000};
	assign rst_rd  = {m0_b, m1_b, 12'h000, per_b, ser_b};

	always_comb begin
		case (bus_i.addr)
			tss_pkg::TRACE_CTRL_IDX:  rmux = {16'h0000, ctrl_rd};
			tss_pkg::TRACE_CFG_IDX:   rmux = cfg_ff;
			tss_pkg::SLV_REFRESH_IDX: rmux = 32'h0000_0000;
			tss_pkg::SLV_ERR_IDX:     rmux = {16'h0000, slv_ff};
			tss_pkg::START_TS_IDX:    rmux = start_ts_ff;
			tss_pkg::LOSS_TS_IDX:     rmux = loss_ts_ff;
			tss_pkg::LOSS_CNT_IDX:    rmux = {16'h0000, loss_cnt_ff};
			tss_pkg::ON_HOURS_IDX:    rmux = {16'h0000, on_hrs_ff};
			tss_pkg::RESTART_IDX:     rmux = {16'h0000, rst_rd};
			default:                  rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= bus_i.rd ? rmux : 32'h0000_0000;
		end
	end
	assign rdata_o = rdata_ff;

	// busy rises right after an accepted sampling start
	busy_start_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		smp_rise && st_ff == tss_pkg::TRC_IDLE |=> st_ff == tss_pkg::TRC_RUN)
		else $error("busy not set after sampling start");
	done_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		smp_rise |=> !done_ff)
		else $error("done not cleared by sampling start");
	done_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$fell(st_ff == tss_pkg::TRC_POST) && st_ff == tss_pkg::TRC_IDLE |-> done_ff)
		else $error("done not set at trace end");
	trig_mon_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		trg_rise |=> tmon_ff && st_ff == tss_pkg::TRC_POST)
		else $error("trigger not recorded");
	// the last post-trigger sample must drop busy and raise done on one edge
	sequence last_post_s;
		st_ff == tss_pkg::TRC_POST && post_end;
	endsequence
	sequence idle_done_s;
		st_ff == tss_pkg::TRC_IDLE && done_ff;
	endsequence
	trace_end_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		last_post_s |=> idle_done_s)
		else $error("busy not cleared at trace end");
	period_smp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		st_ff != tss_pkg::TRC_IDLE && mode == tss_pkg::SMP_PERIODIC && ival_hit |-> sample_o)
		else $error("periodic sample missed");
	cycle_smp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		st_ff != tss_pkg::TRC_IDLE && mode == tss_pkg::SMP_CYCLE && cycle_end_i
		|-> sample_o)
		else $error("cycle end sample missed");
	instr_smp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode == tss_pkg::SMP_INSTR && sample_o |-> trace_sample_instruction_i)
		else $error("instruction sample without instruction");
	// power words carry no reset, so these checks look only one edge after a capture
	start_time_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		power_on_i |=> start_ts_ff == pack_ts($past(now_i)))
		else $error("start-up time not captured");
	loss_time_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		power_loss_i |=> loss_ts_ff == pack_ts($past(now_i)))
		else $error("power loss time not captured");
	loss_count_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mem_corrupt_i |=> loss_cnt_ff == 16'h0000)
		else $error("loss counter not cleared");
	loss_incr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		power_loss_i && !mem_corrupt_i |=> loss_cnt_ff == $past(loss_cnt_ff) + 16'h0001)
		else $error("loss counter not incremented");
	slv_refresh_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_slv && bus_i.wdata[tss_pkg::SLV_REFR_BIT] |=> slv_ff == $past(slv_err_unit_i))
		else $error("slave error unit not refreshed");
	per_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_rst && wd16[tss_pkg::RST_PER_BIT] && !per_b |-> per_restart_o)
		else $error("peripheral restart not issued");
	// a restart bit must not outlive its done pulse unless a new request lands with it
	ser_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		ser_b && ser_done_i && !(wr_rst && wd16[tss_pkg::RST_SER_BIT]) |=> !ser_b)
		else $error("serial restart bit not cleared");
	m1_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		m1_b && m1_done_i && !(wr_rst && wd16[tss_pkg::RST_M1_BIT]) |=> !m1_b)
		else $error("master 1 restart bit not cleared");
	m0_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		m0_b && m0_done_i && !(wr_rst && wd16[tss_pkg::RST_M0_BIT]) |=> !m0_b)
		else $error("master 0 restart bit not cleared");
endmodule

// ### core/tss_pkg.sv
// package: register map, fields and timing constants of the trace and system status words
package tss_pkg;
	// register indices: one word per index, byte address = 4*index
	localparam logic [9:0] TRACE_CTRL_IDX  = 10'h1fc;
	localparam logic [9:0] SLV_REFRESH_IDX = 10'h1fd;
	localparam logic [9:0] START_TS_IDX    = 10'h1fe;
	localparam logic [9:0] LOSS_TS_IDX     = 10'h200;
	localparam logic [9:0] LOSS_CNT_IDX    = 10'h202;
	localparam logic [9:0] ON_HOURS_IDX    = 10'h20b;
	localparam logic [9:0] RESTART_IDX     = 10'h20e;
	localparam logic [9:0] TRACE_CFG_IDX   = 10'h210;
	localparam logic [9:0] SLV_ERR_IDX     = 10'h211;

	// trace control/status bit positions
	localparam int TRC_DONE_BIT   = 12;
	localparam int TRC_BUSY_BIT   = 13;
	localparam int TRC_TRIG_BIT   = 14;
	localparam int TRC_SAMPLE_BIT = 15;
	localparam int TRC_TMON_BIT   = 11;
	// trace config layout
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_IVAL_LSB   = 8;
	localparam int CFG_DELAY_LSB  = 16;
	// restart bits and slave refresh bit
	localparam int RST_SER_BIT    = 0;
	localparam int RST_PER_BIT    = 1;
	localparam int RST_M1_BIT     = 14;
	localparam int RST_M0_BIT     = 15;
	localparam int SLV_REFR_BIT   = 0;

	// reset values
	localparam logic [15:0] TRACE_CTRL_RST = 16'h0000;
	localparam logic [31:0] TRACE_CFG_RST  = 32'h0000_0100;
	localparam logic [15:0] RESTART_RST    = 16'h0000;

	// timing
	localparam int CLK_HZ        = 100_000_000;
	localparam int IVAL_UNIT_MS  = 10;
	localparam int IVAL_MIN_MS   = 10;
	localparam int IVAL_MAX_MS   = 2550;
	localparam int UNIT_CYC      = CLK_HZ / 1000 * IVAL_UNIT_MS;
	localparam int ON_UNIT_HOURS = 10;
	localparam longint ON_UNIT_CYC = 64'(CLK_HZ) * 3600 * ON_UNIT_HOURS;

	typedef enum logic [1:0] {
		SMP_PERIODIC = 2'b00,
		SMP_INSTR    = 2'b01,
		SMP_CYCLE    = 2'b10
	} tss_mode_t;

	typedef enum logic [1:0] {
		TRC_IDLE = 2'b00,
		TRC_RUN  = 2'b01,
		TRC_POST = 2'b10
	} tss_state_t;

	// bcd time carried from the real-time clock
	typedef struct packed {
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} tss_time_t;

	// register bus request
	typedef struct packed {
		logic [9:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tss_bus_t;
endpackage

// ### core/tss_restart.sv
// module: one self-clearing restart request bit with handshake to the unit
`timescale 1ns/100ps
module tss_restart #(
	parameter bit AUTO_CLEAR = 1'b1
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// software side
	input  wire logic set_i,
	input  wire logic clr_i,
	// unit side
	input  wire logic done_i,
	output logic      bit_o,
	output logic      pulse_o
);
	logic bit_ff;
	logic nxt_bit;
	logic rise;

	// a restart fires once on the rising edge of the bit
	assign rise    = set_i & ~bit_ff;
	assign nxt_bit = set_i ? 1'b1 : ((AUTO_CLEAR && done_i) || clr_i) ? 1'b0 : bit_ff;
	assign bit_o   = bit_ff;
	assign pulse_o = rise;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_ff <= 1'b0;
		end else begin
			bit_ff <= nxt_bit;
		end
	end
endmodule

// ### bench/tss_unit_model.sv
// far-side unit model: answers each restart request with a done pulse after a delay
`timescale 1ns/100ps
module tss_unit_model #(
	parameter int DLY = 8
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// restart handshake
	input  wire logic restart_i,
	output logic      done_o
);
	int cnt_ff;
	// a repeated request restarts the count, as a unit that reinitialises again would
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt_ff == 1);
			if (restart_i)
				cnt_ff <= DLY;
			else if (cnt_ff != 0)
				cnt_ff <= cnt_ff - 1;
		end
	end
endmodule

// ### bench/tss_status_words_test.sv
// testbench: register port, timestamps, counters, trace flow and restart bits
`timescale 1ns/100ps
module tss_status_words_test;
	logic               sys_clk_i, rstn_i, power_on_i, power_loss_i, mem_corrupt_i;
	logic               cycle_end_i, trc_instr;
	tss_pkg::tss_bus_t  bus_i;
	tss_pkg::tss_time_t now_i, t1, t2, t3;
	logic [15:0]        slv_err_unit_i, sidx, s;
	logic [31:0]        rdata_o, ev_exp;
	logic               sample_o, trig_o, rd_seen;
	wire  [3:0]         rst_o, done;
	int                 errors, checks_done, seed, cyc, n_smp, n_trg, base, np[4];
	logic [31:0]        exp_q[$];
	int                 bits[3] = '{0, 14, 15};
	int                 map[3]  = '{0, 2, 3};

	tss_status_words #(.ON_UNIT(100), .IVAL_UNIT(4)) dut (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.power_on_i(power_on_i), .power_loss_i(power_loss_i), .mem_corrupt_i(mem_corrupt_i),
		.cycle_end_i(cycle_end_i), .trace_sample_instruction_i(trc_instr), .now_i(now_i),
		.slv_err_unit_i(slv_err_unit_i), .sample_o(sample_o), .sample_idx_o(sidx),
		.trig_o(trig_o), .ser_restart_o(rst_o[0]), .per_restart_o(rst_o[1]),
		.m1_restart_o(rst_o[2]), .m0_restart_o(rst_o[3]), .ser_done_i(done[0]),
		.m1_done_i(done[2]), .m0_done_i(done[3]));
	// serial unit answers fast, masters slowly
	tss_unit_model #(.DLY(3)) u_ser (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.restart_i(rst_o[0]), .done_o(done[0]));
	tss_unit_model #(.DLY(12)) u_m1 (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.restart_i(rst_o[2]), .done_o(done[2]));
	tss_unit_model #(.DLY(12)) u_m0 (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.restart_i(rst_o[3]), .done_o(done[3]));
	// the peripheral port reports no completion, so its slot stays low
	assign done[1] = 1'b0;

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wrap_up;
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task wr(logic [9:0] a, logic [31:0] d);
		@(posedge sys_clk_i);
		bus_i <= {a, d, 1'b1, 1'b0};
		@(posedge sys_clk_i);
		bus_i <= '0;
	endtask

	task rd(logic [9:0] a, logic [31:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk_i);
		bus_i <= {a, 32'h0, 1'b0, 1'b1};
		@(posedge sys_clk_i);
		bus_i <= '0;
	endtask

	// ev = {corrupt, loss, power-on, trace instruction, cycle end}
	task pulse(tss_pkg::tss_time_t t, logic [4:0] ev);
		@(posedge sys_clk_i);
		now_i <= t;
		{mem_corrupt_i, power_loss_i, power_on_i, trc_instr, cycle_end_i} <= ev;
		@(posedge sys_clk_i);
		{mem_corrupt_i, power_loss_i, power_on_i, trc_instr, cycle_end_i} <= 5'h0;
	endtask

	function automatic logic [7:0] bcd(int t, int o);
		bcd = {4'($unsigned($random(seed)) % t), 4'(o + $unsigned($random(seed)) % (10 - o))};
	endfunction

	function automatic tss_pkg::tss_time_t rnd_time();
		rnd_time = {bcd(3, 1), bcd(2, 0), bcd(6, 0), bcd(6, 0)};
	endfunction

	// read data stand only in the cycle after the strobe, so look at them there
	always @(posedge sys_clk_i) rd_seen <= bus_i.rd;
	always @(negedge sys_clk_i) begin
		if (rd_seen === 1'b1) begin
			ev_exp = exp_q.pop_front();
			chk("rdata", rdata_o, ev_exp);
		end
	end

	always @(posedge sys_clk_i) begin
		n_smp += int'(sample_o === 1'b1);
		n_trg += int'(trig_o === 1'b1);
		for (int i = 0; i < 4; i++)
			np[i] += int'(rst_o[i] === 1'b1);
		cyc++;
		if (cyc == 6000) begin
			errors++;
			wrap_up();
		end
	end

	initial begin
		seed = 30;
		{bus_i, now_i, slv_err_unit_i} = '0;
		{power_on_i, power_loss_i, mem_corrupt_i, cycle_end_i, trc_instr} = 5'h0;
		rstn_i = 1'b0;
		repeat (6) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		rd(tss_pkg::TRACE_CTRL_IDX, 32'(tss_pkg::TRACE_CTRL_RST));
		rd(tss_pkg::TRACE_CFG_IDX, tss_pkg::TRACE_CFG_RST);
		rd(tss_pkg::RESTART_IDX, 32'(tss_pkg::RESTART_RST));
		rd(10'h3ff, 32'h0);
		t1 = rnd_time();
		t2 = rnd_time();
		t3 = rnd_time();
		pulse(t1, 5'b00100);
		rd(tss_pkg::START_TS_IDX, t1);
		wr(tss_pkg::LOSS_CNT_IDX, 32'h0);
		repeat (3) pulse(t2, 5'b01000);
		rd(tss_pkg::LOSS_TS_IDX, t2);
		rd(tss_pkg::LOSS_CNT_IDX, 32'h3);
		pulse(t3, 5'b00100);
		rd(tss_pkg::START_TS_IDX, t3);
		rd(tss_pkg::LOSS_TS_IDX, t2);
		rd(tss_pkg::LOSS_CNT_IDX, 32'h3);
		pulse(t3, 5'b11000);
		rd(tss_pkg::LOSS_CNT_IDX, 32'h0);
		wr(tss_pkg::LOSS_CNT_IDX, 32'h5);
		rd(tss_pkg::LOSS_CNT_IDX, 32'h5);
		// on-time tick restarts at power-on, so two whole units lie in 250 cycles
		pulse(t3, 5'b00100);
		wr(tss_pkg::ON_HOURS_IDX, 32'h0);
		repeat (250) @(posedge sys_clk_i);
		rd(tss_pkg::ON_HOURS_IDX, 32'h2);
		s = 16'($random(seed));
		slv_err_unit_i <= s;
		wr(tss_pkg::SLV_REFRESH_IDX, 32'h1);
		rd(tss_pkg::SLV_ERR_IDX, 32'(s));
		for (int k = 0; k < 3; k++) begin
			#1 base = np[map[k]];
			wr(tss_pkg::RESTART_IDX, 32'h1 << bits[k]);
			rd(tss_pkg::RESTART_IDX, 32'h1 << bits[k]);
			repeat (16) @(posedge sys_clk_i);
			rd(tss_pkg::RESTART_IDX, 32'h0);
			chk("restart pulses", 32'(np[map[k]] - base), 32'h1);
		end
		#1 base = np[1];
		wr(tss_pkg::RESTART_IDX, 32'h2);
		wr(tss_pkg::RESTART_IDX, 32'h2);
		rd(tss_pkg::RESTART_IDX, 32'h2);
		wr(tss_pkg::RESTART_IDX, 32'h0);
		rd(tss_pkg::RESTART_IDX, 32'h0);
		#1 chk("peripheral pulses", 32'(np[1] - base), 32'h1);
		for (int m = 0; m < 3; m++) begin
			wr(tss_pkg::TRACE_CFG_IDX, {16'h0002, 8'h01, 6'h0, 2'(m)});
			wr(tss_pkg::TRACE_CTRL_IDX, 32'h8000);
			rd(tss_pkg::TRACE_CTRL_IDX, 32'ha000);
			#1 base = n_smp;
			if (m == 0) begin
				repeat (40) @(posedge sys_clk_i);
				#1 chk("periodic samples", 32'(n_smp - base), 32'ha);
			end else begin
				repeat (3) pulse(t3, 5'b00010);
				repeat (3) pulse(t3, 5'b00001);
				#1 chk("event samples", 32'(n_smp - base), 32'h3);
				chk("sample index", 32'(sidx), 32'h3);
			end
			base = n_trg;
			wr(tss_pkg::TRACE_CTRL_IDX, 32'hc000);
			#1 chk("trigger pulses", 32'(n_trg - base), 32'h1);
			base = n_smp;
			repeat (30) pulse(t3, {3'b000, m == 1, m == 2});
			#1 chk("post-trigger samples", 32'(n_smp - base), 32'h3);
			rd(tss_pkg::TRACE_CTRL_IDX, 32'hd800);
			wr(tss_pkg::TRACE_CTRL_IDX, 32'h0);
		end
		rd(tss_pkg::TRACE_CTRL_IDX, 32'h1800);
		repeat (3) @(posedge sys_clk_i);
		wrap_up();
	end
endmodule
